// ### hdl/stage_d_defs.svh
// Offsets, field positions and reset value of the stage D control register
`ifndef STAGE_D_DEFS_SVH
`define STAGE_D_DEFS_SVH

// =============================================================
// Byte addresses (most significant byte at the lowest address)
`define SD_ADDR_HI 8'h89
`define SD_ADDR_MID 8'h8a
`define SD_ADDR_LO 8'h8b

// =============================================================
// Field positions
`define SD_MODE_MSB 23
`define SD_MODE_LSB 20
`define SD_TYPE_BIT 19
`define SD_POL_BIT 18
`define SD_SEL_MSB 17
`define SD_SEL_LSB 16
`define SD_PER_MSB 15
`define SD_PER_LSB 0

// =============================================================
// Values
`define SD_MODE_FRAME 4'hf
`define SD_RESET_VAL 24'h000040
`define SD_MIN_RATIO 24'h000002

`endif

// ### hdl/stage_d_pkg.sv
// Types shared by the stage D post-divider and frame pulse logic
package stage_d_pkg;
  typedef enum logic [1:0] {REL_A, REL_B, REL_C, REL_RSVD} rel_sel_t;
  typedef enum logic {MODE_DIV, MODE_FRAME} out_mode_t;
endpackage

// ### hdl/stage_d_ratio_div.sv
// Normal-mode ratio divider for stage D
`timescale 1ns/1ns
`default_nettype none
`include "stage_d_defs.svh"
module stage_d_ratio_div (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic run_i,
  input wire logic [23:0] ratio_i,
  // Divided clock
  output logic clk_o
);
  logic [23:0] cnt_reg;
  logic [23:0] cnt_next;
  logic out_reg;
  logic out_next;
  logic [23:0] ratio_eff;
  logic [23:0] half;

  // =============================================================
  // Counter and duty shaping
  always_comb begin
    // Ratios below two cannot be made from this clock; treated as two
    ratio_eff = (ratio_i < `SD_MIN_RATIO) ? `SD_MIN_RATIO : ratio_i;
    // High for half the ratio: exact 50% for even, one cycle short for odd
    half = ratio_eff >> 1;
    if (!run_i) begin
      cnt_next = 24'h000000;
    end else if (cnt_reg >= ratio_eff - 24'h000001) begin
      cnt_next = 24'h000000;
    end else begin
      cnt_next = cnt_reg + 24'h000001;
    end
    out_next = run_i && (cnt_next < half);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 24'h000000;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign clk_o = out_reg;
endmodule
`default_nettype wire

// ### hdl/stage_d_post_div.sv
// Stage D post-divider / frame pulse generator with its control register
`timescale 1ns/1ns
`default_nettype none
`include "stage_d_defs.svh"
module stage_d_post_div
  import stage_d_pkg::*;
(
  // Clock (synthesizer VCO) and reset
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  // Configuration port, byte wide
  input wire logic CFG_WR_I,
  input wire logic CFG_RD_I,
  input wire logic [7:0] CFG_ADDR_I,
  input wire logic [7:0] CFG_WDATA_I,
  output logic [7:0] CFG_RDATA_O,
  // Sibling post-divider clocks of the same synthesizer
  input wire logic REL_CLK_A_I,
  input wire logic REL_CLK_B_I,
  input wire logic REL_CLK_C_I,
  // Output routing: frame pulse sent to a configurable pin
  input wire logic PIN_ROUTE_I,
  // Stage D output
  output logic STAGE_D_OUT_O
);
  logic [23:0] ctrl_reg;
  logic [23:0] ctrl_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rel_prev_reg;
  logic rel_prev_next;
  logic [15:0] per_cnt_reg;
  logic [15:0] per_cnt_next;
  logic mid_pulse_reg;
  logic mid_pulse_next;
  logic out_reg;
  logic out_next;
  out_mode_t mode;
  rel_sel_t sel;
  logic rel_now;
  logic rel_rise;
  logic rel_fall;
  logic [15:0] per_last;
  logic edge_pulse;
  logic raw_pulse;
  logic div_clk;

  // =============================================================
  // Control register over the configuration port
  always_comb begin
    ctrl_next = ctrl_reg;
    // Each byte lands at once; a half-written setting may run briefly
    if (CFG_WR_I) begin
      unique case (CFG_ADDR_I)
        `SD_ADDR_HI: ctrl_next[23:16] = CFG_WDATA_I;
        `SD_ADDR_MID: ctrl_next[15:8] = CFG_WDATA_I;
        `SD_ADDR_LO: ctrl_next[7:0] = CFG_WDATA_I;
        default: ctrl_next = ctrl_reg;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      ctrl_reg <= `SD_RESET_VAL;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // =============================================================
  // Read data, held until the next read
  always_comb begin
    rdata_next = rdata_reg;
    if (CFG_RD_I) begin
      unique case (CFG_ADDR_I)
        `SD_ADDR_HI: rdata_next = ctrl_reg[23:16];
        `SD_ADDR_MID: rdata_next = ctrl_reg[15:8];
        `SD_ADDR_LO: rdata_next = ctrl_reg[7:0];
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // =============================================================
  // Field decode
  always_comb begin
    if (ctrl_reg[`SD_MODE_MSB:`SD_MODE_LSB] == `SD_MODE_FRAME) begin
      mode = MODE_FRAME;
    end else begin
      mode = MODE_DIV;
    end
  end

  always_comb begin
    sel = rel_sel_t'(ctrl_reg[`SD_SEL_MSB:`SD_SEL_LSB]);
    // Reserved code reads as a still clock: the count freezes, so an edge-type output frozen at count zero stays active
    unique case (sel)
      REL_A: rel_now = REL_CLK_A_I;
      REL_B: rel_now = REL_CLK_B_I;
      REL_C: rel_now = REL_CLK_C_I;
      REL_RSVD: rel_now = 1'b0;
    endcase
    rel_rise = rel_now && !rel_prev_reg;
    rel_fall = !rel_now && rel_prev_reg;
    // Zero spacing treated as one period
    if (ctrl_reg[`SD_PER_MSB:`SD_PER_LSB] == 16'h0000) begin
      per_last = 16'h0000;
    end else begin
      per_last = ctrl_reg[`SD_PER_MSB:`SD_PER_LSB] - 16'h0001;
    end
  end

  // =============================================================
  // Frame pulse timing
  always_comb begin
    rel_prev_next = rel_now;
    per_cnt_next = per_cnt_reg;
    mid_pulse_next = mid_pulse_reg;
    if (mode != MODE_FRAME) begin
      per_cnt_next = 16'h0000;
      mid_pulse_next = 1'b0;
    end else begin
      // Frame boundary is the related rising edge that wraps the count
      if (rel_rise) begin
        if (per_cnt_reg >= per_last) begin
          per_cnt_next = 16'h0000;
        end else begin
          per_cnt_next = per_cnt_reg + 16'h0001;
        end
      end
      // Falling edge to falling edge around the boundary
      if (rel_fall) begin
        mid_pulse_next = (per_cnt_reg == per_last);
      end
      // No related edges here, so a pulse left high would stick
      if (sel == REL_RSVD) begin
        mid_pulse_next = 1'b0;
      end
    end
  end

  // =============================================================
  // Output select
  always_comb begin
    // Rising edge at the boundary to the next rising edge
    edge_pulse = (per_cnt_reg == 16'h0000);
    if (ctrl_reg[`SD_TYPE_BIT]) begin
      raw_pulse = edge_pulse;
    end else begin
      raw_pulse = mid_pulse_reg;
    end
    if (mode == MODE_FRAME) begin
      // Pin routing flips the programmed sense once more
      out_next = raw_pulse ^ ctrl_reg[`SD_POL_BIT] ^ PIN_ROUTE_I;
    end else begin
      out_next = div_clk;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      rel_prev_reg <= 1'b0;
      per_cnt_reg <= 16'h0000;
      mid_pulse_reg <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      rel_prev_reg <= rel_prev_next;
      per_cnt_reg <= per_cnt_next;
      mid_pulse_reg <= mid_pulse_next;
      out_reg <= out_next;
    end
  end

  // =============================================================
  // Normal divider; ratio above the maximum is software's concern
  stage_d_ratio_div u_ratio_div (
    .clk_i(CLK_SYS_I),
    .rst_i(SYS_RST_I),
    .run_i(mode == MODE_DIV),
    .ratio_i(ctrl_reg),
    .clk_o(div_clk)
  );

  assign CFG_RDATA_O = rdata_reg;
  assign STAGE_D_OUT_O = out_reg;
endmodule
`default_nettype wire

// ### tb/stage_d_post_div_monitor.sv
// Port checker for the stage D post-divider
`timescale 1ns/1ns
`default_nettype none
module stage_d_post_div_monitor (
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  input wire logic CFG_WR_I,
  input wire logic CFG_RD_I,
  input wire logic [7:0] CFG_ADDR_I,
  input wire logic [7:0] CFG_WDATA_I,
  input wire logic [7:0] CFG_RDATA_O,
  input wire logic PIN_ROUTE_I,
  input wire logic STAGE_D_OUT_O
);
  logic [23:0] sh, n;
  logic [7:0] rexp, hc, lc, sc;
  logic dv, fc;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  // ====
  // Shadow register and run counters
  always_ff @(posedge CLK_SYS_I) begin
    hc <= (SYS_RST_I || !STAGE_D_OUT_O) ? 8'h00 : hc + 8'h01;
    lc <= (SYS_RST_I || STAGE_D_OUT_O) ? 8'h00 : lc + 8'h01;
    sc <= (SYS_RST_I || CFG_WR_I) ? 8'h00 : sc + {7'h00, sc != 8'hff};
    if (SYS_RST_I) sh <= 24'h000040;
    else if (CFG_WR_I && CFG_ADDR_I == 8'h89) sh[23:16] <= CFG_WDATA_I;
    else if (CFG_WR_I && CFG_ADDR_I == 8'h8a) sh[15:8] <= CFG_WDATA_I;
    else if (CFG_WR_I && CFG_ADDR_I == 8'h8b) sh[7:0] <= CFG_WDATA_I;
  end
  assign n = (sh < 24'h000002) ? 24'h000002 : sh;
  // Only short ratios are judged, so 8-bit run counters suffice
  assign dv = sc == 8'hff && sh[23:20] != 4'hf && sh < 24'h000100;
  assign fc = sh[23:20] == 4'hf && sh[17:16] == 2'b11 && !sh[19];
  assign rexp = CFG_ADDR_I == 8'h89 ? sh[23:16] : CFG_ADDR_I == 8'h8a ? sh[15:8] :
    CFG_ADDR_I == 8'h8b ? sh[7:0] : 8'h00;
  a_rd_value: assert property (CFG_RD_I |=> CFG_RDATA_O == $past(rexp))
    else $error("read data wrong");
  a_rd_hold: assert property (!CFG_RD_I |=> $stable(CFG_RDATA_O))
    else $error("read data moved");
  a_rst_out: assert property ($fell(SYS_RST_I) |-> !STAGE_D_OUT_O && CFG_RDATA_O == 8'h00)
    else $error("reset state wrong");
  a_div_high: assert property (dv && $fell(STAGE_D_OUT_O) |-> {16'h0, hc} == n / 2)
    else $error("high run wrong");
  a_div_low: assert property (dv && $rose(STAGE_D_OUT_O) |-> {16'h0, lc} == n - n / 2)
    else $error("low run wrong");
  a_high_bound: assert property (dv |-> {16'h0, hc} <= n / 2)
    else $error("high run too long");
  a_low_bound: assert property (dv |-> {16'h0, lc} <= n - n / 2)
    else $error("low run too long");
  a_fr_idle: assert property ((fc && $stable(PIN_ROUTE_I) && $stable(sh)) [*3] |=>
    STAGE_D_OUT_O == ($past(sh[18]) ^ $past(PIN_ROUTE_I)))
    else $error("idle level wrong");
  cover property (dv && $fell(STAGE_D_OUT_O));
  cover property (fc);
  cover property (CFG_RD_I && CFG_ADDR_I == 8'h8c);
endmodule
bind stage_d_post_div stage_d_post_div_monitor i_mon (.CLK_SYS_I(CLK_SYS_I),
  .SYS_RST_I(SYS_RST_I), .CFG_WR_I(CFG_WR_I), .CFG_RD_I(CFG_RD_I), .CFG_ADDR_I(CFG_ADDR_I),
  .CFG_WDATA_I(CFG_WDATA_I), .CFG_RDATA_O(CFG_RDATA_O), .PIN_ROUTE_I(PIN_ROUTE_I),
  .STAGE_D_OUT_O(STAGE_D_OUT_O));
`default_nettype wire

// ### tb/synth_post_divider_frame_pulse_tb.sv
// Self-checking bench for the stage D post-divider
`timescale 1ns/1ns
`default_nettype none
module synth_post_divider_frame_pulse_tb;
  logic clk = 0, rst = 1, wr = 0, rd = 0, ra = 0, rb = 0, rc = 0, route = 0, pol;
  logic [7:0] addr = 8'h00, wdat = 8'h00, d;
  logic [23:0] h, q, nr;
  wire logic [7:0] rdat;
  wire logic dout;
  int failures = 0, check_count = 0, seed = 32'h897c, rcnt = 0, k, i, p, sel, ty, rp, ph0;
  stage_d_post_div i_dut (.CLK_SYS_I(clk), .SYS_RST_I(rst), .CFG_WR_I(wr), .CFG_RD_I(rd),
    .CFG_ADDR_I(addr), .CFG_WDATA_I(wdat), .CFG_RDATA_O(rdat), .REL_CLK_A_I(ra),
    .REL_CLK_B_I(rb), .REL_CLK_C_I(rc), .PIN_ROUTE_I(route), .STAGE_D_OUT_O(dout));
  initial forever #50 clk = ~clk;
  // Sibling clocks with periods of 4, 6 and 8 cycles
  always @(posedge clk) begin
    rcnt <= (rcnt + 1) % 24;
    ra <= rcnt % 4 < 2;
    rb <= rcnt % 6 < 3;
    rc <= rcnt % 8 < 4;
  end
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task wr8(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk) begin wr <= 1; addr <= a; wdat <= v; end
    @(posedge clk) wr <= 0;
  endtask
  task cfg(input logic [23:0] v);
    wr8(8'h89, v[23:16]);
    wr8(8'h8a, v[15:8]);
    wr8(8'h8b, v[7:0]);
  endtask
  task rd8(input logic [7:0] a);
    @(posedge clk) begin rd <= 1; addr <= a; end
    @(posedge clk) rd <= 0;
    @(negedge clk) d = rdat;
  endtask
  task waitv(input logic v);
    for (k = 0; k < 3000 && dout !== v; k++) @(negedge clk);
    if (k == 3000) begin failures++; end_sim; end
  endtask
  // Skips a partial pulse and one whole pulse, then times one active run and one whole period
  task meas(input logic act);
    repeat (2) begin waitv(!act); waitv(act); end
    for (h = 0; h < 3000 && dout === act; h++) @(negedge clk);
    for (q = h; q < 3000 && dout !== act; q++) @(negedge clk);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    rd8(8'h89); chk(d, 8'h00);
    rd8(8'h8b); chk(d, 8'h40);
    meas(1); chk(h, 32); chk(q, 64);
    wr8(8'h8c, 8'h5a); rd8(8'h8c); chk(d, 8'h00);
    $display("register test done");
    for (i = 0; i < 8; i++) begin
      nr = (i == 0) ? 0 : 24'({$random(seed)} % 40);
      cfg(nr); rd8(8'h8b); chk(d, nr[7:0]);
      repeat (260) @(posedge clk);
      if (nr < 2) nr = 2;
      meas(1); chk(h, nr / 2); chk(q, nr);
    end
    $display("divide test done");
    for (sel = 0; sel < 3; sel++) for (ty = 0; ty < 2; ty++) begin
      p = 2 + {$random(seed)} % 4;
      rp = 4 + 2 * sel;
      pol = 1'($random(seed));
      @(posedge clk) route <= 1'($random(seed));
      cfg({4'hf, ty[0], pol, sel[1:0], 16'(p)});
      meas(!(pol ^ route)); chk(h, rp); chk(q, p * rp);
      if (ty == 0) ph0 = rcnt % rp;
      else chk((rcnt % rp + rp - ph0) % rp, rp / 2);
    end
    cfg(24'hf30004); repeat (8) @(posedge clk); @(negedge clk); chk(24'(dout), 24'(route));
    $display("frame test done");
    end_sim;
  end
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    end_sim;
  end
endmodule
`default_nettype wire
